// ===== rtl/fpsc_core.sv
`timescale 1ns/100ps
// Summary of operation
// - Sign bit 0 is positive, 1 is negative.
// - Significand is a one-bit integer part plus a fraction.
// - Single word is 32 bits: sign, biased exponent, fraction.
// - Stored exponent is true exponent plus 127.
// - Biased exponent 1 through 254 is a normal number.
// - Normalising drops leading zeros, one exponent step each.
// - Plus and minus zero differ only in sign, equal value.
// - Non-zero value with zero exponent is denormal.
// - Below exponent -126, shift right until exponent is -126.
// - If every bit shifts out, result is zero.
// - Results stay normal where possible, denormal only otherwise.
// - Creating a denormal result raises underflow.
// - Denormal source operand raises denormal-operand flag.
// - Each encoding falls in exactly one class.
// - Exponent 255 with zero fraction is a signed infinity.
// - Exponent 255, non-zero fraction is NaN; top bit quiet.
module fpsc_core
  import fpsc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Operand side
  input  wire logic                    opValid,
  input  wire logic [FPSC_WORD_W-1:0]  opWord,
  output logic                         opClassValid_reg,
  output logic [FPSC_CLASS_W-1:0]      opClass_reg,
  output logic                         opSign_reg,
  output logic [9:0]                   opExp_reg,
  output logic [FPSC_SIG_W-1:0]        opSig_reg,
  output logic                         denormOperand_reg,
  output logic                         zeroEqual_reg,
  // Raw result side
  input  wire logic                    resValid,
  input  wire logic                    resSign,
  input  wire logic [9:0]              resExp,
  input  wire logic [FPSC_SIG_W-1:0]   resSig,
  output logic                         packValid_reg,
  output logic [FPSC_WORD_W-1:0]       packWord_reg,
  output logic                         underflow_reg
);

  // Operand field split
  logic                   inSign;
  logic [FPSC_EXP_W-1:0]  inExp;
  logic [FPSC_FRAC_W-1:0] inFrac;
  logic                   fracZero;
  logic [FPSC_CLASS_W-1:0] class_next;

  assign inSign   = opWord[FPSC_SIGN_POS];
  assign inExp    = opWord[FPSC_SIGN_POS-1:FPSC_EXP_LSB];
  assign inFrac   = opWord[FPSC_FRAC_W-1:0];
  assign fracZero = (inFrac == '0);

  always_comb begin
    class_next = '0;
    if (opWord == FPSC_INDEFINITE) begin
      class_next[FPSC_C_INDEF] = 1'b1;
    end else if (inExp == FPSC_EXP_MAX) begin
      if (fracZero) begin
        class_next[FPSC_C_INF] = 1'b1;
      end else if (inFrac[FPSC_QUIET_POS]) begin
        class_next[FPSC_C_QNAN] = 1'b1;
      end else begin
        class_next[FPSC_C_SNAN] = 1'b1;
      end
    end else if (inExp == FPSC_EXP_ZERO) begin
      if (fracZero) begin
        class_next[FPSC_C_ZERO] = 1'b1;
      end else begin
        class_next[FPSC_C_DENORM] = 1'b1;
      end
    end else begin
      class_next[FPSC_C_NORM] = 1'b1;
    end
  end

  // Class valid pulse, one cycle after acceptance
  always_ff @(posedge clk) begin
    if (srst) begin
      opClassValid_reg <= 1'b0;
    end else begin
      opClassValid_reg <= opValid;
    end
  end

  // Class holds until the next operand so later stages can reuse it
  always_ff @(posedge clk) begin
    if (srst) begin
      opClass_reg <= FPSC_CLASS_RESET;
    end else if (opValid) begin
      opClass_reg <= class_next;
    end
  end

  // Flag pulses once, so a held class cannot raise it again
  always_ff @(posedge clk) begin
    if (srst) begin
      denormOperand_reg <= 1'b0;
    end else begin
      denormOperand_reg <= opValid && class_next[FPSC_C_DENORM];
    end
  end

  // Registered sign of the operand
  always_ff @(posedge clk) begin
    if (srst) begin
      opSign_reg <= 1'b0;
    end else if (opValid) begin
      opSign_reg <= inSign;
    end
  end

  // Decoded operand: unbiased exponent and explicit integer bit
  always_ff @(posedge clk) begin
    if (srst) begin
      opExp_reg <= '0;
      opSig_reg <= '0;
    end else if (opValid) begin
      // Denormals use the minimum exponent with integer bit zero
      if (inExp == FPSC_EXP_ZERO) begin
        opExp_reg <= FPSC_EMIN;
        opSig_reg <= {1'b0, inFrac};
      end else begin
        opExp_reg <= {2'b00, inExp} - FPSC_BIAS;
        opSig_reg <= {1'b1, inFrac};
      end
    end
  end

  // Both zeros compare equal regardless of sign
  always_ff @(posedge clk) begin
    if (srst) begin
      zeroEqual_reg <= 1'b0;
    end else if (opValid) begin
      zeroEqual_reg <= (inExp == FPSC_EXP_ZERO) && fracZero;
    end
  end

  // Result normalisation
  logic [4:0]            lz;
  logic                  sigZero;
  logic signed [10:0]    normExp;
  logic [FPSC_SIG_W-1:0] normSig;
  logic signed [10:0]    shiftAmt;
  logic [FPSC_SIG_W-1:0] denSig;
  logic [FPSC_WORD_W-1:0] pack_next;
  logic                  uflow_next;
  logic signed [10:0]    eMinS;
  logic signed [10:0]    eMaxS;
  logic signed [10:0]    biasS;
  logic signed [10:0]    sigWidthS;

  // Limits widened once so every range compare stays signed
  assign eMinS     = $signed({FPSC_EMIN[9], FPSC_EMIN});
  assign eMaxS     = $signed({1'b0, FPSC_EMAX});
  assign biasS     = $signed({1'b0, FPSC_BIAS});
  assign sigWidthS = 11'(FPSC_SIG_W);

  fpsc_lzc #(.W(FPSC_SIG_W), .CW(5)) lzcInst (
    .din     (resSig),
    .count   (lz),
    .allZero (sigZero)
  );

  always_comb begin
    normSig    = resSig << lz;
    normExp    = $signed({resExp[9], resExp}) - $signed({6'b0, lz});
    shiftAmt   = eMinS - normExp;
    denSig     = '0;
    pack_next  = '0;
    uflow_next = 1'b0;
    if (sigZero) begin
      pack_next = {resSign, 31'h00000000};
    end else if (normExp >= eMinS) begin
      // Normal whenever range allows
      if (normExp > eMaxS) begin
        // Overflow saturates to the signed infinity
        pack_next = {resSign, FPSC_EXP_MAX, 23'h000000};
      end else begin
        pack_next = {resSign,
                     FPSC_EXP_W'(normExp + biasS),
                     normSig[FPSC_FRAC_W-1:0]};
      end
    end else begin
      // Gradual underflow: one right shift per exponent step
      if (shiftAmt >= sigWidthS) begin
        denSig = '0;
      end else begin
        denSig = normSig >> shiftAmt[4:0];
      end
      pack_next  = {resSign, FPSC_EXP_ZERO, denSig[FPSC_FRAC_W-1:0]};
      // Rounding is not done here, so only a surviving bit is a denormal
      uflow_next = (denSig != '0);
    end
  end

  // Pack valid pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      packValid_reg <= 1'b0;
    end else begin
      packValid_reg <= resValid;
    end
  end

  // Underflow pulses with the result that caused it, never held
  always_ff @(posedge clk) begin
    if (srst) begin
      underflow_reg <= 1'b0;
    end else begin
      underflow_reg <= resValid && uflow_next;
    end
  end

  // Packed word holds until the next raw result
  always_ff @(posedge clk) begin
    if (srst) begin
      packWord_reg <= '0;
    end else if (resValid) begin
      packWord_reg <= pack_next;
    end
  end

endmodule // fpsc_core

// ===== rtl/fpsc_pkg.sv
package fpsc_pkg;

  localparam int FPSC_WORD_W   = 32;
  localparam int FPSC_EXP_W    = 8;
  localparam int FPSC_FRAC_W   = 23;
  localparam int FPSC_SIG_W    = 24;
  localparam int FPSC_SIGN_POS = 31;
  localparam int FPSC_EXP_LSB  = 23;
  localparam int FPSC_QUIET_POS = 22;

  localparam logic [7:0] FPSC_EXP_ZERO = 8'h00;
  localparam logic [7:0] FPSC_EXP_MAX  = 8'hff;
  localparam logic [7:0] FPSC_EXP_NMAX = 8'hfe;
  localparam logic [9:0] FPSC_BIAS     = 10'h07f;
  localparam logic [9:0] FPSC_EMIN     = 10'h382;
  localparam logic [9:0] FPSC_EMAX     = 10'h07f;

  localparam logic [31:0] FPSC_INDEFINITE = 32'hffc00000;

  localparam int FPSC_CLASS_W = 7;
  localparam int FPSC_C_ZERO  = 0;
  localparam int FPSC_C_DENORM = 1;
  localparam int FPSC_C_NORM  = 2;
  localparam int FPSC_C_INF   = 3;
  localparam int FPSC_C_QNAN  = 4;
  localparam int FPSC_C_SNAN  = 5;
  localparam int FPSC_C_INDEF = 6;

  localparam logic [6:0] FPSC_CLASS_RESET = 7'h00;

endpackage : fpsc_pkg

// ===== rtl/fpsc_lzc.sv
`timescale 1ns/100ps
// Leading zero count of a significand
module fpsc_lzc #(
  parameter int W  = 24,
  parameter int CW = 5
) (
  // Data
  input  wire logic [W-1:0]  din,
  // Result
  output logic      [CW-1:0] count,
  output logic               allZero
);

  always_comb begin
    count   = CW'(W);
    allZero = 1'b1;
    for (int i = 0; i < W; i++) begin
      if (din[i]) begin
        count   = CW'(W - 1 - i);
        allZero = 1'b0;
      end
    end
  end

endmodule // fpsc_lzc

// ===== verification/fpsc_core_monitor.sv
`timescale 1ns/100ps
module fpsc_core_monitor
  import fpsc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Operand side
  input wire logic        opValid,
  input wire logic [31:0] opWord,
  input wire logic        opClassValid_reg,
  input wire logic [6:0]  opClass_reg,
  input wire logic        opSign_reg,
  input wire logic [9:0]  opExp_reg,
  input wire logic [23:0] opSig_reg,
  input wire logic        denormOperand_reg,
  input wire logic        zeroEqual_reg,
  // Result side
  input wire logic        resValid,
  input wire logic        resSign,
  input wire logic [9:0]  resExp,
  input wire logic [23:0] resSig,
  input wire logic        packValid_reg,
  input wire logic [31:0] packWord_reg,
  input wire logic        underflow_reg
);
  wire [7:0] e  = opWord[30:23];
  wire [9:0] ue = {2'h0, e} - 10'h07f;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  op_lat_a: assert property (
    opValid |=> opClassValid_reg)
    else $error("class valid late");
  one_hot_a: assert property (
    opClassValid_reg |-> $onehot(opClass_reg))
    else $error("class not one-hot");
  den_flag_a: assert property (
    denormOperand_reg == ($past(opValid) && $past(e) == 8'h00
    && $past(opWord[22:0]) != 0))
    else $error("denormal flag wrong");
  inf_cls_a: assert property (
    opValid && e == 8'hff && opWord[22:0] == 0 |=> opClass_reg[3])
    else $error("infinity missed");
  snan_cls_a: assert property (
    opValid && e == 8'hff && !opWord[22] && opWord[21:0] != 0
    |=> opClass_reg[5])
    else $error("snan missed");
  norm_exp_a: assert property (
    opValid && e != 8'h00 && e != 8'hff
    |=> opClass_reg[2] && opExp_reg == $past(ue))
    else $error("normal wrong");
  zero_cls_a: assert property (
    opValid && opWord[30:0] == 0 |=> zeroEqual_reg && opClass_reg[0]
    && opSign_reg == $past(opWord[31]))
    else $error("zero wrong");
  pack_lat_a: assert property (
    resValid |=> packValid_reg)
    else $error("pack valid late");
  uflow_flag_a: assert property (
    packValid_reg |-> underflow_reg
    == (packWord_reg[30:23] == 0 && packWord_reg[22:0] != 0))
    else $error("underflow flag wrong");
  cover property (denormOperand_reg);
  cover property (underflow_reg);
  cover property (opClassValid_reg && opClass_reg[6]);
  cover property (packValid_reg && packWord_reg[30:23] == 8'hff);
endmodule // fpsc_core_monitor

bind fpsc_core fpsc_core_monitor mon (.*);

// ===== verification/fpsc_sink.sv
`timescale 1ns/100ps
// Next pipeline stage: counts packed results it consumes
module fpsc_sink (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Packed results
  input  wire logic       packValid,
  output logic      [7:0] seen
);
  always_ff @(posedge clk) begin
    if (srst) seen <= 8'h00;
    else if (packValid) seen <= seen + 8'h01;
  end
endmodule // fpsc_sink

// ===== verification/tb_fp_single_classify_denorm.sv
`timescale 1ns/100ps
module tb_fp_single_classify_denorm;
  logic clk = 1'b0, srst = 1'b1, opValid = 1'b0, resValid = 1'b0;
  logic resSign = 1'b0, cv, sg, dn, ze, pv, uf;
  logic [31:0] opWord = 32'h0, pw;
  logic [9:0]  resExp = 10'h000, ex;
  logic [23:0] resSig = 24'h000000, sig;
  logic [6:0]  cls;
  logic [7:0]  seen;
  int mismatches = 0, checked = 0;
  always #4 clk = ~clk;
  fpsc_core uut (.clk(clk), .srst(srst), .opValid(opValid), .opWord(opWord),
    .opClassValid_reg(cv), .opClass_reg(cls), .opSign_reg(sg),
    .opExp_reg(ex), .opSig_reg(sig), .denormOperand_reg(dn),
    .zeroEqual_reg(ze), .resValid(resValid), .resSign(resSign),
    .resExp(resExp), .resSig(resSig), .packValid_reg(pv),
    .packWord_reg(pw), .underflow_reg(uf));
  fpsc_sink sink (.clk(clk), .srst(srst), .packValid(pv), .seen(seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [31:0] w);
    @(posedge clk) opValid <= 1'b1;
    opWord <= w;
    @(posedge clk) opValid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic res(input logic s, input logic [9:0] e,
    input logic [23:0] m, input logic [31:0] w, input logic u);
    @(posedge clk) resValid <= 1'b1;
    resSign <= s;
    resExp <= e;
    resSig <= m;
    @(posedge clk) resValid <= 1'b0;
    @(negedge clk);
    chk(pw, w);
    chk(uf, u);
  endtask
  task automatic t_class;
    logic [31:0] w [9] = '{32'h0, 32'h80000000, 32'h1, 32'h00800000,
      32'h7f7fffff, 32'hff800000, 32'h7fc00000, 32'h7f800001, 32'hffc00000};
    logic [6:0] c [9] = '{7'h01, 7'h01, 7'h02, 7'h04, 7'h04, 7'h08, 7'h10,
      7'h20, 7'h40};
    for (int i = 0; i < 9; i++) begin
      op(w[i]);
      chk(cv, 1'b1);
      chk(cls, c[i]);
      chk(dn, c[i][1]);
      chk(ze, c[i][0]);
    end
    $display("class test done");
  endtask
  task automatic t_fields;
    op(32'h43322000);
    chk(ex, 10'h007);
    chk(sig, 24'hb22000);
    op(32'hc3322000);
    chk(sg, 1'b1);
    op(32'h00000001);
    chk(ex, 10'h382);
    chk(sig, 24'h000001);
    @(negedge clk);
    chk(cv, 1'b0);
    chk(dn, 1'b0);
    $display("field test done");
  endtask
  task automatic t_pack;
    res(1'b0, 10'h37f, 24'hae0000, 32'h0015c000, 1'b1);
    res(1'b0, 10'h000, 24'h800000, 32'h3f800000, 1'b0);
    res(1'b0, 10'h003, 24'h200000, 32'h40000000, 1'b0);
    res(1'b0, 10'h382, 24'h400000, 32'h00400000, 1'b1);
    res(1'b1, 10'h360, 24'h800000, 32'h80000000, 1'b0);
    res(1'b0, 10'h382, 24'h800000, 32'h00800000, 1'b0);
    res(1'b1, 10'h080, 24'h800000, 32'hff800000, 1'b0);
    @(negedge clk);
    chk(seen, 8'h07);
    $display("pack test done");
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_class;
    t_fields;
    t_pack;
    results;
  end
  initial begin
    #20000;
    mismatches++;
    results;
  end
endmodule // tb_fp_single_classify_denorm
